// [src/serial_comm_register_interface.sv]
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Rx counter pointer: bits 7:1 counter location, bit 0 picks regfile over memory.
// - Rx address pointer: bits 7:1 pointer location, bit 0 picks address extension.
// - Tx counter pointer: bits 7:1 counter location, bit 0 picks regfile source.
// - Tx address pointer: bits 7:1 pointer location, bit 0 picks address extension.
// - Vector base is written in bits 7:3; bit 0 always reads zero.
// - Vector bits 2:1 encode the active interrupt source.
// - In character search mode, received words compare with the compare register; match sets pending.
// - After an address match every following data word reaches the receive buffer.
// - Mask bit 7 picks buffer-empty or shift-empty as transmit source.
// - DMA block ends set end-of-block flags; only software clears them.
// - Mask bits 4, 3, 2 enable error, address and break interrupts.
// - Mask bits 1 and 0 gate data interrupts, never DMA requests.
// - Overrun flag sets when a word lands before the previous was read.
// - Framing flag sets when a word lacks a valid stop bit.
// - Framing error during address monitoring still delivers the word and interrupts.
// - Parity flag sets when the received parity bit is wrong.
// - Address pending flag sets on the selected address event.
// - Break pending sets when the input stays low a whole word.
// - Data pending sets whenever a word enters the receive buffer.
// - Buffer-empty and shift-empty flags set on their empty events.
// - Software may clear status flags but never set them.
// - Word end moves data to the buffer; short formats read ones above.
// - Buffer write loads transmit buffer, moved to shifter when free.
// - Enable and mode bits select the address event among four kinds.
module serial_comm_register_interface (
   // Clock, reset and freeze
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic CE,
   // AXI4-Lite write channels
   input wire logic [serial_comm_pkg::ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read channels
   input wire logic [serial_comm_pkg::ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Receive shift side
   input wire logic RX_WORD_DONE,
   input wire logic [7:0] RX_WORD,
   input wire logic RX_NINTH_BIT,
   input wire logic RX_STOP_BAD,
   input wire logic RX_PARITY_BAD,
   input wire logic RX_BREAK_SEEN,
   // Character format settings
   input wire logic ADDRESS_MODE_ENABLE,
   input wire logic ADDRESS_MODE_SELECT,
   input wire logic ADDRESS_FILTER_ON,
   input wire logic [1:0] WORD_LENGTH,
   // Transmit shift side
   input wire logic TX_SHIFT_BUSY,
   input wire logic TX_SHIFT_DONE,
   output logic TX_LOAD,
   output logic [7:0] TX_DATA,
   // DMA side
   input wire logic RX_DMA_ENABLE,
   input wire logic TX_DMA_ENABLE,
   input wire logic RX_DMA_END,
   input wire logic TX_DMA_END,
   output logic RX_DMA_REQ,
   output logic TX_DMA_REQ,
   output logic [6:0] RX_COUNTER_LOC,
   output logic RX_REGFILE_MEMORY_SELECT,
   output logic [6:0] RX_POINTER_LOC,
   output logic RX_POINTER_EXTENSION_SELECT,
   output logic [6:0] TX_COUNTER_LOC,
   output logic TX_REGFILE_MEMORY_SELECT,
   output logic [6:0] TX_POINTER_LOC,
   output logic TX_POINTER_EXTENSION_SELECT,
   // Interrupt request to the controller
   output logic INT_REQ,
   output logic [7:0] INT_VECTOR
);
   import serial_comm_pkg::*;

   logic [ADDR_W-1:0] aw_addr_r;
   logic aw_held_r;
   logic [7:0] w_data_r;
   logic w_strb_r;
   logic w_held_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [7:0] rdata_r;
   logic [7:0] rx_cnt_ptr_r;
   logic [7:0] rx_adr_ptr_r;
   logic [7:0] tx_cnt_ptr_r;
   logic [7:0] tx_adr_ptr_r;
   logic [4:0] vbase_r;
   logic [7:0] compare_r;
   logic tx_src_sel_r;
   logic [4:0] irq_enable_r;
   logic [7:0] rx_buffer_r;
   logic unread_r;
   logic [7:0] tx_buffer_r;
   logic tx_full_r;
   logic tx_load_r;
   logic [7:0] tx_data_r;
   logic selected_r;
   logic after_break_r;
   logic int_req_r;
   logic [7:0] int_vector_r;
   logic [NUM_FLAGS-1:0] flag_set;
   logic [NUM_FLAGS-1:0] flag_clr;
   logic [NUM_FLAGS-1:0] flags;
   logic [7:0] status;
   addr_mode_type addr_mode;
   logic is_addr_word;
   logic mode_hit;

   // Write path decode
   wire [7:0] wr_idx = aw_addr_r[9:2];
   wire wr_mapped = (aw_addr_r[11:10] == 2'h0) && (wr_idx >= IDX_RX_CNT_PTR)
      && (wr_idx <= IDX_BUFFER);
   wire wr_go = CE & aw_held_r & w_held_r & ~bvalid_r;
   wire wr_en = wr_go & wr_mapped & w_strb_r;
   wire wr_status = wr_en && (wr_idx == IDX_STATUS);
   wire wr_mask = wr_en && (wr_idx == IDX_MASK);
   wire wr_tx_buf = wr_en && (wr_idx == IDX_BUFFER);

   // Read path decode, answered on the edge that takes the address
   wire [7:0] rd_idx = ARADDR[9:2];
   wire rd_mapped = (ARADDR[11:10] == 2'h0) && (rd_idx >= IDX_RX_CNT_PTR)
      && (rd_idx <= IDX_BUFFER);
   wire rd_go = ARVALID & ARREADY;
   wire rd_rx_buf = rd_go && rd_mapped && (rd_idx == IDX_BUFFER);

   // Handshakes; gated by the enable so nothing is taken while frozen
   assign AWREADY = CE & ~aw_held_r;
   assign WREADY = CE & ~w_held_r;
   assign ARREADY = CE & ~rvalid_r;
   assign BVALID = bvalid_r;
   assign BRESP = bresp_r;
   assign RVALID = rvalid_r;
   assign RRESP = rresp_r;
   assign RDATA = {24'h000000, rdata_r};

   // Write address and data may come in either order
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_held_r <= 1'b0;
         w_data_r <= REG_RESET;
         w_strb_r <= 1'b0;
      end else if (CE) begin
         if (AWVALID && !aw_held_r) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= AWADDR;
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
         if (WVALID && !w_held_r) begin
            w_held_r <= 1'b1;
            w_data_r <= WDATA[7:0];
            w_strb_r <= WSTRB[0];
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer with a slave error
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (CE) begin
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (BREADY) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read return word, with the vector built from live source code
   logic [1:0] src_code;
   wire [7:0] vector_word = {vbase_r, src_code, 1'b0};
   wire [7:0] mask_word = {tx_src_sel_r, flags[FLAG_RX_EOB], flags[FLAG_TX_EOB],
      irq_enable_r};
   wire [7:0] rd_word =
      (rd_idx == IDX_RX_CNT_PTR) ? rx_cnt_ptr_r :
      (rd_idx == IDX_RX_ADR_PTR) ? rx_adr_ptr_r :
      (rd_idx == IDX_TX_CNT_PTR) ? tx_cnt_ptr_r :
      (rd_idx == IDX_TX_ADR_PTR) ? tx_adr_ptr_r :
      (rd_idx == IDX_VECTOR) ? vector_word :
      (rd_idx == IDX_COMPARE) ? compare_r :
      (rd_idx == IDX_MASK) ? mask_word :
      (rd_idx == IDX_STATUS) ? status :
      (rd_idx == IDX_BUFFER) ? rx_buffer_r : REG_RESET;

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= REG_RESET;
      end else if (CE) begin
         if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= rd_mapped ? rd_word : REG_RESET;
         end else if (RREADY) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // Plain software registers; DMA pointers steer the DMA unit directly
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         rx_cnt_ptr_r <= REG_RESET;
         rx_adr_ptr_r <= REG_RESET;
         tx_cnt_ptr_r <= REG_RESET;
         tx_adr_ptr_r <= REG_RESET;
         vbase_r <= VBASE_RESET;
         compare_r <= REG_RESET;
         tx_src_sel_r <= 1'b0;
         irq_enable_r <= ENABLE_RESET;
      end else if (wr_en) begin
         if (wr_idx == IDX_RX_CNT_PTR) rx_cnt_ptr_r <= w_data_r;
         if (wr_idx == IDX_RX_ADR_PTR) rx_adr_ptr_r <= w_data_r;
         if (wr_idx == IDX_TX_CNT_PTR) tx_cnt_ptr_r <= w_data_r;
         if (wr_idx == IDX_TX_ADR_PTR) tx_adr_ptr_r <= w_data_r;
         if (wr_idx == IDX_VECTOR) vbase_r <= w_data_r[7:3];
         if (wr_idx == IDX_COMPARE) compare_r <= w_data_r;
         if (wr_mask) begin
            tx_src_sel_r <= w_data_r[MASK_TX_SRC_SEL];
            irq_enable_r <= w_data_r[4:0];
         end
      end
   end

   assign RX_COUNTER_LOC = rx_cnt_ptr_r[7:1];
   assign RX_REGFILE_MEMORY_SELECT = rx_cnt_ptr_r[0];
   assign RX_POINTER_LOC = rx_adr_ptr_r[7:1];
   assign RX_POINTER_EXTENSION_SELECT = rx_adr_ptr_r[0];
   assign TX_COUNTER_LOC = tx_cnt_ptr_r[7:1];
   assign TX_REGFILE_MEMORY_SELECT = tx_cnt_ptr_r[0];
   assign TX_POINTER_LOC = tx_adr_ptr_r[7:1];
   assign TX_POINTER_EXTENSION_SELECT = tx_adr_ptr_r[0];

   // Address event selection
   assign addr_mode = addr_mode_type'({ADDRESS_MODE_ENABLE, ADDRESS_MODE_SELECT});
   wire char_eq = (RX_WORD == compare_r);
   always_comb begin
      unique case (addr_mode)
         AMODE_NINTH: begin
            is_addr_word = RX_NINTH_BIT;
            mode_hit = RX_NINTH_BIT;
         end
         AMODE_MATCH: begin
            is_addr_word = 1'b0;
            mode_hit = char_eq;
         end
         AMODE_MATCH_NINTH: begin
            is_addr_word = RX_NINTH_BIT;
            mode_hit = RX_NINTH_BIT & char_eq;
         end
         AMODE_AFTER_BREAK: begin
            is_addr_word = after_break_r;
            mode_hit = after_break_r & char_eq;
         end
      endcase
   end

   // Character search never filters; other address modes drop foreign data while the filter is on
   wire word_in = CE & RX_WORD_DONE;
   wire addr_active = ADDRESS_FILTER_ON | (addr_mode == AMODE_MATCH);
   wire filtering = addr_active & (addr_mode != AMODE_MATCH);
   wire monitoring = filtering & ~selected_r;
   wire addr_hit = word_in & addr_active & mode_hit;
   wire deliver = word_in & (~filtering | (selected_r & ~is_addr_word)
      | (monitoring & RX_STOP_BAD));
   wire [7:0] fill = (WORD_LENGTH == 2'h0) ? FILL_5 : (WORD_LENGTH == 2'h1) ? FILL_6 :
      (WORD_LENGTH == 2'h2) ? FILL_7 : FILL_8;

   // Receive buffer, unread tracking and address selection state
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         rx_buffer_r <= REG_RESET;
         unread_r <= 1'b0;
         selected_r <= 1'b0;
         after_break_r <= 1'b0;
      end else if (CE) begin
         if (deliver) rx_buffer_r <= RX_WORD | fill;
         unread_r <= deliver | (unread_r & ~rd_rx_buf);
         if (word_in && filtering && is_addr_word) selected_r <= mode_hit;
         if (RX_BREAK_SEEN) begin
            after_break_r <= 1'b1;
         end else if (word_in) begin
            after_break_r <= 1'b0;
         end
      end
   end

   // Transmit buffer; a write in the moving cycle keeps the new byte pending
   wire tx_move = CE & tx_full_r & ~TX_SHIFT_BUSY;
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         tx_buffer_r <= REG_RESET;
         tx_full_r <= 1'b0;
         tx_load_r <= 1'b0;
         tx_data_r <= REG_RESET;
      end else if (CE) begin
         tx_load_r <= tx_move;
         if (tx_move) tx_data_r <= tx_buffer_r;
         if (wr_tx_buf) begin
            tx_buffer_r <= w_data_r;
            tx_full_r <= 1'b1;
         end else if (tx_move) begin
            tx_full_r <= 1'b0;
         end
      end
   end
   assign TX_LOAD = tx_load_r;
   assign TX_DATA = tx_data_r;

   // Hardware set events for each flag
   assign flag_set[ST_OVERRUN] = deliver & unread_r;
   assign flag_set[ST_FRAMING] = word_in & RX_STOP_BAD;
   assign flag_set[ST_PARITY] = word_in & RX_PARITY_BAD;
   assign flag_set[ST_ADDR] = addr_hit;
   assign flag_set[ST_BREAK] = CE & RX_BREAK_SEEN;
   assign flag_set[ST_RX_DATA] = deliver;
   assign flag_set[ST_TX_BUF] = tx_move;
   assign flag_set[ST_TX_SHIFT] = CE & TX_SHIFT_DONE;
   assign flag_set[FLAG_TX_EOB] = CE & TX_DMA_END;
   assign flag_set[FLAG_RX_EOB] = CE & RX_DMA_END;

   // Software clears with a zero and cannot set anything
   assign flag_clr[7:0] = wr_status ? ~w_data_r : 8'h00;
   assign flag_clr[FLAG_TX_EOB] = wr_mask & ~w_data_r[MASK_TX_EOB];
   assign flag_clr[FLAG_RX_EOB] = wr_mask & ~w_data_r[MASK_RX_EOB];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
         sticky_flag u_flag (
            .clk(CLOCK),
            .rst_b(RST_B),
            .ce(CE),
            .set_in(flag_set[gi]),
            .clear_in(flag_clr[gi]),
            .flag_out(flags[gi])
         );
      end
   endgenerate
   assign status = flags[7:0];

   // Interrupt sources; in DMA the data and shift events yield to end-of-block
   wire tx_empty_src = tx_src_sel_r ? status[ST_TX_BUF] : status[ST_TX_SHIFT];
   wire rx_errors = status[ST_OVERRUN] | status[ST_FRAMING] | status[ST_PARITY];
   wire err_irq = irq_enable_r[MASK_RX_ERR] & rx_errors;
   wire ab_irq = (irq_enable_r[MASK_RX_ADDR] & status[ST_ADDR])
      | (irq_enable_r[MASK_RX_BRK] & status[ST_BREAK]);
   wire rxd_irq = irq_enable_r[MASK_RX_DATA] & ((status[ST_RX_DATA] & ~RX_DMA_ENABLE)
      | flags[FLAG_RX_EOB]);
   wire txd_irq = irq_enable_r[MASK_TX_DATA] & ((tx_empty_src & ~TX_DMA_ENABLE)
      | flags[FLAG_TX_EOB]);
   assign src_code = err_irq ? SRC_RX_ERROR : ab_irq ? SRC_BREAK_ADDR :
      rxd_irq ? SRC_RX_DATA : SRC_TX;

   // DMA requests ignore the data masks; an error halts receive DMA
   assign RX_DMA_REQ = RX_DMA_ENABLE & status[ST_RX_DATA] & ~rx_errors;
   assign TX_DMA_REQ = TX_DMA_ENABLE & tx_empty_src;

   // Registered request and vector toward the interrupt controller
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         int_req_r <= 1'b0;
         int_vector_r <= REG_RESET;
      end else if (CE) begin
         int_req_r <= err_irq | ab_irq | rxd_irq | txd_irq;
         int_vector_r <= vector_word;
      end
   end
   assign INT_REQ = int_req_r;
   assign INT_VECTOR = int_vector_r;

   // Checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);

   sequence s_tx_ready;
      CE && tx_full_r && !TX_SHIFT_BUSY && !wr_tx_buf;
   endsequence
   sequence s_tx_moved;
      TX_LOAD && status[ST_TX_BUF] && !tx_full_r;
   endsequence
   property p_vector_read;
      (rd_go && rd_mapped && rd_idx == IDX_VECTOR) |=>
         (RDATA[0] == 1'b0) && (RDATA[2:1] == $past(src_code)) && RVALID;
   endproperty
   a_vector_read: assert property (p_vector_read) else $error("vector read wrong");
   property p_addr_pending;
      addr_hit |=> status[ST_ADDR];
   endproperty
   a_addr_pending: assert property (p_addr_pending) else $error("no address flag");
   property p_overrun;
      (deliver && unread_r) |=> status[ST_OVERRUN] && status[ST_RX_DATA];
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");
   property p_framing;
      (word_in && RX_STOP_BAD) |=> status[ST_FRAMING];
   endproperty
   a_framing: assert property (p_framing) else $error("framing missed");
   property p_monitor_framing;
      (word_in && monitoring && RX_STOP_BAD) |=> status[ST_RX_DATA]
         && rx_buffer_r == ($past(RX_WORD) | $past(fill));
   endproperty
   a_monitor_framing: assert property (p_monitor_framing) else $error("bad word dropped");
   property p_parity;
      (word_in && RX_PARITY_BAD) |=> status[ST_PARITY];
   endproperty
   a_parity: assert property (p_parity) else $error("parity missed");
   property p_break;
      (CE && RX_BREAK_SEEN) |=> status[ST_BREAK];
   endproperty
   a_break: assert property (p_break) else $error("break missed");
   property p_tx_move;
      s_tx_ready |=> s_tx_moved;
   endproperty
   a_tx_move: assert property (p_tx_move) else $error("transmit move wrong");
   property p_status_write;
      (wr_status && flag_set[7:0] == 8'h00) |=>
         status == ($past(status) & $past(w_data_r));
   endproperty
   a_status_write: assert property (p_status_write) else $error("status write wrong");
   property p_eob;
      (CE && RX_DMA_END) |=> flags[FLAG_RX_EOB] [*2];
   endproperty
   a_eob: assert property (p_eob) else $error("end of block lost");
endmodule
`default_nettype wire

// [src/serial_comm_pkg.sv]
package serial_comm_pkg;
   // Register indices; the bus byte address is four times the index
   localparam logic [7:0] IDX_RX_CNT_PTR = 8'hF0;
   localparam logic [7:0] IDX_RX_ADR_PTR = 8'hF1;
   localparam logic [7:0] IDX_TX_CNT_PTR = 8'hF2;
   localparam logic [7:0] IDX_TX_ADR_PTR = 8'hF3;
   localparam logic [7:0] IDX_VECTOR = 8'hF4;
   localparam logic [7:0] IDX_COMPARE = 8'hF5;
   localparam logic [7:0] IDX_MASK = 8'hF6;
   localparam logic [7:0] IDX_STATUS = 8'hF7;
   localparam logic [7:0] IDX_BUFFER = 8'hF8;
   localparam int ADDR_W = 12;
   // Values after reset (undefined in hardware, chosen as zero)
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [4:0] ENABLE_RESET = 5'h00;
   localparam logic [4:0] VBASE_RESET = 5'h00;
   localparam logic FLAG_RESET = 1'b0;
   // Interrupt mask field positions
   localparam int MASK_TX_SRC_SEL = 7;
   localparam int MASK_RX_EOB = 6;
   localparam int MASK_TX_EOB = 5;
   localparam int MASK_RX_ERR = 4;
   localparam int MASK_RX_ADDR = 3;
   localparam int MASK_RX_BRK = 2;
   localparam int MASK_RX_DATA = 1;
   localparam int MASK_TX_DATA = 0;
   // Status field positions; end-of-block flags follow in the flag vector
   localparam int ST_OVERRUN = 7;
   localparam int ST_FRAMING = 6;
   localparam int ST_PARITY = 5;
   localparam int ST_ADDR = 4;
   localparam int ST_BREAK = 3;
   localparam int ST_RX_DATA = 2;
   localparam int ST_TX_BUF = 1;
   localparam int ST_TX_SHIFT = 0;
   localparam int FLAG_TX_EOB = 8;
   localparam int FLAG_RX_EOB = 9;
   localparam int NUM_FLAGS = 10;
   // Encoded interrupt source in vector bits 2:1
   localparam logic [1:0] SRC_RX_ERROR = 2'h0;
   localparam logic [1:0] SRC_BREAK_ADDR = 2'h1;
   localparam logic [1:0] SRC_RX_DATA = 2'h2;
   localparam logic [1:0] SRC_TX = 2'h3;
   // Upper-bit fill for 5, 6, 7 and 8 bit words
   localparam logic [7:0] FILL_5 = 8'hE0;
   localparam logic [7:0] FILL_6 = 8'hC0;
   localparam logic [7:0] FILL_7 = 8'h80;
   localparam logic [7:0] FILL_8 = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Address event selection from the enable and mode bits
   typedef enum logic [1:0] {AMODE_NINTH, AMODE_MATCH, AMODE_MATCH_NINTH,
      AMODE_AFTER_BREAK} addr_mode_type;
endpackage

// [src/sticky_flag.sv]
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
   // Clocking
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Hardware set and software clear
   input wire logic set_in,
   input wire logic clear_in,
   output logic flag_out
);
   import serial_comm_pkg::*;

   logic flag_r;
   logic flag_nxt;

   // Set beats clear so an event in the clearing cycle is kept
   assign flag_nxt = set_in | (flag_r & ~clear_in);
   assign flag_out = flag_r;

   // Holds while the enable is low
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_r <= FLAG_RESET;
      end else if (ce) begin
         flag_r <= flag_nxt;
      end
   end
endmodule
`default_nettype wire

// [test/serial_station.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_station (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Transmit shifter side
   input wire logic tx_load,
   input wire logic [7:0] tx_data,
   output logic tx_busy,
   output logic tx_done,
   // Receive shifter side
   output logic rx_done,
   output logic [7:0] rx_word,
   output logic rx_stop_bad,
   output logic rx_par_bad
);
   logic [7:0] last_tx;
   int busy_cnt;
   int n_sent;
   int n_done;
   assign tx_busy = (busy_cnt != 0);
   // Shifter busy for a short word after each load, then one done pulse
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_cnt <= 0;
         tx_done <= 1'b0;
      end else begin
         tx_done <= (busy_cnt == 1);
         if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
         if (tx_load) begin
            busy_cnt <= 8;
            last_tx <= tx_data;
            n_sent <= n_sent + 1;
         end
         if (busy_cnt == 1) n_done <= n_done + 1;
      end
   end
   initial begin
      n_sent = 0;
      n_done = 0;
      rx_done = 1'b0;
      rx_word = 8'hFF;
      rx_stop_bad = 1'b1;
      rx_par_bad = 1'b1;
   end
   // One received word; idle lines show the inverse so stale data never matches
   task automatic send(input logic [7:0] w, input logic fe, input logic pe);
      rx_done <= 1'b1;
      rx_word <= w;
      rx_stop_bad <= fe;
      rx_par_bad <= pe;
      @(posedge clk);
      rx_done <= 1'b0;
      rx_word <= ~w;
      rx_stop_bad <= ~fe;
      rx_par_bad <= ~pe;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   import serial_comm_pkg::*;
   logic clk, rst_b, ce, awvalid, wvalid, bready, arvalid, rready, amsel, rxd_en, rx_end, tx_end;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, v, d;
   logic [1:0] wl, r;
   logic ninth, brk, address_mode_enable, afilt;
   wire awready, wready, bvalid, arready, rvalid, rx_done, rx_sb, rx_pb, tx_busy, tx_done;
   wire tx_load, int_req, rx_req, tx_req;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] rx_word, tx_data, int_vec;
   wire [3:0][7:0] ptr;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   serial_comm_register_interface u_dut (.CLOCK(clk), .RST_B(rst_b), .CE(ce),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF),
      .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .RX_WORD_DONE(rx_done), .RX_WORD(rx_word),
      .RX_NINTH_BIT(ninth), .RX_STOP_BAD(rx_sb), .RX_PARITY_BAD(rx_pb), .RX_BREAK_SEEN(brk),
      .ADDRESS_MODE_ENABLE(address_mode_enable), .ADDRESS_MODE_SELECT(amsel), .ADDRESS_FILTER_ON(afilt),
      .WORD_LENGTH(wl), .TX_SHIFT_BUSY(tx_busy), .TX_SHIFT_DONE(tx_done), .TX_LOAD(tx_load),
      .TX_DATA(tx_data), .RX_DMA_ENABLE(rxd_en), .TX_DMA_ENABLE(rxd_en), .RX_DMA_END(rx_end),
      .TX_DMA_END(tx_end), .RX_DMA_REQ(rx_req), .TX_DMA_REQ(tx_req),
      .RX_COUNTER_LOC(ptr[0][7:1]), .RX_REGFILE_MEMORY_SELECT(ptr[0][0]),
      .RX_POINTER_LOC(ptr[1][7:1]), .RX_POINTER_EXTENSION_SELECT(ptr[1][0]),
      .TX_COUNTER_LOC(ptr[2][7:1]), .TX_REGFILE_MEMORY_SELECT(ptr[2][0]),
      .TX_POINTER_LOC(ptr[3][7:1]), .TX_POINTER_EXTENSION_SELECT(ptr[3][0]),
      .INT_REQ(int_req), .INT_VECTOR(int_vec));
   serial_station u_far (.clk(clk), .rst_b(rst_b), .tx_load(tx_load), .tx_data(tx_data),
      .tx_busy(tx_busy), .tx_done(tx_done), .rx_done(rx_done), .rx_word(rx_word),
      .rx_stop_bad(rx_sb), .rx_par_bad(rx_pb));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Write handshake; readies sampled mid-cycle since inputs only move at edges
   task automatic wr(input logic [7:0] idx, input logic [7:0] x);
      logic a, w, b;
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= {24'h0, x};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge clk);
         a = awready & awvalid;
         w = wready & wvalid;
         b = bvalid;
         @(posedge clk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] q, output logic [1:0] s);
      logic a, rv;
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      rv = 1'b0;
      while (!rv) begin
         @(negedge clk);
         a = arready & arvalid;
         rv = rvalid;
         q = rdata;
         s = rresp;
         @(posedge clk);
         if (a) arvalid <= 1'b0;
      end
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] q;
      logic [1:0] s;
      rd(idx, q, s);
      chk(q, {24'h0, e});
      chk({30'h0, s}, {30'h0, RESP_OKAY});
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard, well beyond the hundred-odd cycles the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready, amsel, rxd_en, rx_end, tx_end} = '0;
      {awaddr, araddr, wdata, wl, ninth, brk, address_mode_enable, afilt} = '0;
      ce = 1'b1;
      v = $urandom(32'hE61F);
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(8'h00, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         wr(8'(IDX_RX_CNT_PTR + i), v[7:0]);
         rchk(8'(IDX_RX_CNT_PTR + i), v[7:0]);
         chk({24'h0, ptr[i]}, {24'h0, v[7:0]});
      end
      wr(IDX_VECTOR, 8'hFF);
      wr(IDX_MASK, 8'h1F);
      rchk(IDX_VECTOR, 8'hFE);
      u_far.send(8'h13, 1'b0, 1'b0);
      rchk(IDX_STATUS, 8'h04);
      rchk(IDX_VECTOR, 8'hFC);
      u_far.send(8'h01, 1'b1, 1'b1);
      rchk(IDX_STATUS, 8'hE4);
      chk({31'h0, int_req}, 32'h1);
      rchk(IDX_BUFFER, 8'hE1);
      rchk(IDX_VECTOR, 8'hF8);
      chk({24'h0, int_vec}, 32'hF8);
      wr(IDX_STATUS, 8'h7F);
      rchk(IDX_STATUS, 8'h64);
      wr(IDX_STATUS, 8'h00);
      rchk(IDX_STATUS, 8'h00);
      amsel <= 1'b1;
      wl <= 2'h3;
      wr(IDX_COMPARE, 8'h5A);
      u_far.send(8'h5A, 1'b0, 1'b0);
      rchk(IDX_STATUS, 8'h14);
      rchk(IDX_VECTOR, 8'hFA);
      rchk(IDX_BUFFER, 8'h5A);
      // Ninth-bit filtering: bad-stop word while monitoring, then select and deliver
      amsel <= 1'b0;
      afilt <= 1'b1;
      u_far.send(8'h33, 1'b1, 1'b0);
      rchk(IDX_BUFFER, 8'h33);
      u_far.send(8'h44, 1'b0, 1'b0);
      ninth <= 1'b1;
      u_far.send(8'h55, 1'b0, 1'b0);
      ninth <= 1'b0;
      u_far.send(8'h66, 1'b0, 1'b0);
      rchk(IDX_STATUS, 8'h54);
      rchk(IDX_BUFFER, 8'h66);
      wr(IDX_STATUS, 8'h00);
      // Address after break: the matching word is taken as an address
      address_mode_enable <= 1'b1;
      amsel <= 1'b1;
      brk <= 1'b1;
      @(posedge clk);
      brk <= 1'b0;
      u_far.send(8'h5A, 1'b0, 1'b0);
      rchk(IDX_STATUS, 8'h18);
      address_mode_enable <= 1'b0;
      afilt <= 1'b0;
      wr(IDX_STATUS, 8'h00);
      v = $urandom;
      wr(IDX_BUFFER, v[7:0]);
      while (u_far.n_done == 0) @(posedge clk);
      @(posedge clk);
      rchk(IDX_STATUS, 8'h03);
      chk({24'h0, u_far.last_tx}, {24'h0, v[7:0]});
      rx_end <= 1'b1;
      tx_end <= 1'b1;
      @(posedge clk);
      rx_end <= 1'b0;
      tx_end <= 1'b0;
      rchk(IDX_MASK, 8'h7F);
      wr(IDX_MASK, 8'h1F);
      rchk(IDX_MASK, 8'h1F);
      // DMA takes over: requests rise, data interrupts stay quiet
      rxd_en <= 1'b1;
      u_far.send(8'h77, 1'b0, 1'b0);
      chk({29'h0, int_req, rx_req, tx_req}, 32'h3);
      end_sim();
   end
endmodule
`default_nettype wire
